// ### common/iwd_pkg.sv
/*
  iwd_pkg: constants, register indices, field positions and carrier types
  of the watchdog / serial EEPROM / card-number block.
  assumes a 50 MHz clock and a 32-bit APB with word-aligned registers.
*/
package iwd_pkg;
  localparam int DATA_W = 16;
  localparam int PADDR_W = 12;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 8;

  // printed offsets are register indices, byte address is four times
  localparam logic [7:0] IDX_PRESET_LO = 8'h34;
  localparam logic [7:0] IDX_PRESET_HI = 8'h36;
  localparam logic [7:0] IDX_CTL = 8'h38;
  localparam logic [7:0] IDX_RELOAD = 8'h3a;
  localparam logic [7:0] IDX_EE_PORT = 8'h3c;
  localparam logic [7:0] IDX_CARD = 8'h3e;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h44;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h46;

  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_IRQEN_BIT = 1;
  localparam int CTL_FLAG_BIT = 2;
  localparam int RELOAD_BIT = 0;
  localparam int EE_DO_BIT = 0;
  localparam int EE_DI_BIT = 1;
  localparam int EE_CLK_BIT = 2;
  localparam int EE_CS_BIT = 3;
  localparam int IRQ_EXPIRY_BIT = 0;
  localparam int IRQ_BOOT_BIT = 1;
  localparam int IRQ_W = 2;

  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 100;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_HALF_NS = 500;
  localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int EE_ADDR_W = 6;
  localparam logic [2:0] EE_READ_OP = 3'h6;
  localparam logic [EE_ADDR_W-1:0] EE_PWRUP_BASE = 6'h00;
  localparam logic [EE_ADDR_W-1:0] EE_OVF_BASE = 6'h10;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic di;
  } iwd_ee_pins_t;

  function automatic logic [PADDR_W-1:0] byteAddr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
endpackage

// ### rtl/iwd_word_mem.sv
/*
  iwd_word_mem: small word memory with registered read data.
  assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ns
module iwd_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ### rtl/iwd_ee_reader.sv
/*
  iwd_ee_reader: reads one 16-bit word from a three-wire serial EEPROM.
  assumes the data-out line is already synchronised to clk.
*/
`timescale 1ns/1ns
module iwd_ee_reader import iwd_pkg::*; #(
  parameter int ABITS = EE_ADDR_W,
  parameter int HALF = EE_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [ABITS-1:0] addr,
  input wire logic doIn,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] data,
  output iwd_ee_pins_t pins
);
  localparam int CMD_BITS = 3 + ABITS;
  localparam int TOTAL = CMD_BITS + DATA_W;
  localparam int HW = $clog2(HALF + 1);
  localparam int BW = $clog2(TOTAL + 1);

  typedef enum logic [1:0] {RD_IDLE, RD_LOW, RD_HIGH, RD_END} iwd_rd_state_t;

  iwd_rd_state_t state_q;
  logic [HW-1:0] halfCnt_q;
  logic [BW-1:0] bitCnt_q;
  logic [CMD_BITS-1:0] cmd_q;
  logic halfEnd;

  assign halfEnd = halfCnt_q == HW'(HALF - 1);
  assign busy = state_q != RD_IDLE;

  always_ff @(posedge clk) begin
    if (rst || state_q == RD_IDLE || halfEnd) begin
      halfCnt_q <= '0;
    end else begin
      halfCnt_q <= halfCnt_q + HW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RD_IDLE;
      bitCnt_q <= '0;
      cmd_q <= '0;
      data <= '0;
      pins <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        RD_IDLE: begin
          if (start) begin
            cmd_q <= {EE_READ_OP, addr};
            pins.cs <= 1'b1;
            pins.sclk <= 1'b0;
            pins.di <= EE_READ_OP[2];
            bitCnt_q <= '0;
            state_q <= RD_LOW;
          end
        end
        RD_LOW: begin
          if (halfEnd) begin
            pins.sclk <= 1'b1;
            state_q <= RD_HIGH;
          end
        end
        RD_HIGH: begin
          if (halfEnd) begin
            pins.sclk <= 1'b0;
            if (bitCnt_q >= BW'(CMD_BITS)) begin
              data <= {data[DATA_W-2:0], doIn};
            end
            cmd_q <= {cmd_q[CMD_BITS-2:0], 1'b0};
            pins.di <= cmd_q[CMD_BITS-2];
            bitCnt_q <= bitCnt_q + BW'(1);
            state_q <= (bitCnt_q == BW'(TOTAL - 1)) ? RD_END : RD_LOW;
          end
        end
        RD_END: begin
          if (halfEnd) begin
            pins <= '0;
            done <= 1'b1;
            state_q <= RD_IDLE;
          end
        end
        default: begin
          state_q <= RD_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rtl/iwd_top.sv
/*
  iwd_top: watchdog down-counter, serial EEPROM port, output presets
  and card-number register behind an APB slave.
  assumes the EEPROM data-out pin and the card switches are asynchronous.
*/
// Design decision made here: the APB slave port.
//
// Contract
// RULE1 - 32-bit preset, low half at 0x34, high half at 0x36, read/write
// RULE2 - counter decrements once every 100 ns
// RULE3 - control bit 0 set starts countdown from preset, clear disables
// RULE4 - control bit 1 enables interrupt when counter reaches zero
// RULE5 - control read returns run enable bit 0, interrupt enable bit 1
// RULE6 - control read bit 2 is one while count equals zero
// RULE7 - writing 0 to reload bit 0 reloads preset, 1 leaves counter
// RULE8 - software should use the control register rather than reload
// RULE9 - reading 0x3C bit 0 gives EEPROM data-out level
// RULE10 - writes to 0x3C drive chip select bit 3, clock bit 2, data bit 1
// RULE11 - EEPROM words 0x00..0x03 hold power-up output values, port pairs
// RULE12 - EEPROM words 0x10..0x13 hold overflow output values, same order
// RULE13 - 4-bit card number at 0x3E, bit 0 is least significant
// RULE14 - switch ON reads 0, OFF reads 1
// RULE15 - counter stops at zero, flag stays until reload or disable
// RULE16 - at zero, overflow output values are loaded onto outputs
`timescale 1ns/1ns
module iwd_top import iwd_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int EE_HALF_CYCLES = EE_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeDataOut,
  output iwd_ee_pins_t eePins,
  input wire logic [3:0] cardNumberSwitch,
  output logic [NUM_PORTS*PORT_W-1:0] portOutputs,
  output logic expiryFlag,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef enum logic [1:0] {AP_FETCH, AP_WAIT, AP_APPLY, AP_IDLE} iwd_ap_state_t;

  function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
    return a == byteAddr(idx);
  endfunction

  function automatic logic [EE_ADDR_W-1:0] eeWordAddr(input logic [2:0] slot);
    return (slot[2] ? EE_OVF_BASE : EE_PWRUP_BASE) | EE_ADDR_W'(slot[1:0]);
  endfunction

  // input synchronisers
  logic doMeta_q;
  logic doSync_q;
  logic [3:0] swMeta_q;
  logic [3:0] swSync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      doMeta_q <= 1'b0;
      doSync_q <= 1'b0;
      swMeta_q <= 4'h0;
      swSync_q <= 4'h0;
    end else begin
      doMeta_q <= eeDataOut;
      doSync_q <= doMeta_q;
      swMeta_q <= cardNumberSwitch;
      swSync_q <= swMeta_q;
    end
  end

  // bus decode
  logic setup;
  logic wrEn;
  logic wrPresetLo;
  logic wrPresetHi;
  logic wrCtl;
  logic wrReload;
  logic wrEePort;
  logic wrStat;
  logic wrMask;

  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pwrite;
  assign wrPresetLo = wrEn & hit(paddr, IDX_PRESET_LO);
  assign wrPresetHi = wrEn & hit(paddr, IDX_PRESET_HI);
  assign wrCtl = wrEn & hit(paddr, IDX_CTL);
  assign wrReload = wrEn & hit(paddr, IDX_RELOAD);
  assign wrEePort = wrEn & hit(paddr, IDX_EE_PORT);
  assign wrStat = wrEn & hit(paddr, IDX_IRQ_STAT);
  assign wrMask = wrEn & hit(paddr, IDX_IRQ_MASK);
  assign pready = psel & penable;

  // software registers
  logic [31:0] preset_q;
  logic run_q;
  logic irqEn_q;
  iwd_ee_pins_t hostPins_q;
  logic [IRQ_W-1:0] mask_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      preset_q <= PRESET_RST;
    end else begin
      if (wrPresetLo) begin
        preset_q[15:0] <= pwdata[15:0]; // see RULE1
      end
      if (wrPresetHi) begin
        preset_q[31:16] <= pwdata[15:0]; // see RULE1
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
      irqEn_q <= 1'b0;
    end else if (wrCtl) begin
      run_q <= pwdata[CTL_RUN_BIT]; // see RULE3
      irqEn_q <= pwdata[CTL_IRQEN_BIT]; // see RULE4
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hostPins_q <= '0;
    end else if (wrEePort) begin
      hostPins_q.cs <= pwdata[EE_CS_BIT]; // see RULE10
      hostPins_q.sclk <= pwdata[EE_CLK_BIT]; // see RULE10
      hostPins_q.di <= pwdata[EE_DI_BIT]; // see RULE10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= IRQ_MASK_RST;
    end else if (wrMask) begin
      mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // watchdog counter
  logic [31:0] count_q;
  logic [TW-1:0] tick_q;
  logic tickEnd;
  logic loadReq;
  logic expiry;

  assign tickEnd = tick_q == TW'(TICK_CYCLES - 1);
  // start on 0->1, reload on a written zero, and disable all restart from preset
  assign loadReq = (wrCtl & (pwdata[CTL_RUN_BIT] ^ run_q)) // see RULE3
    | (wrReload & ~pwdata[RELOAD_BIT]); // see RULE7
  assign expiry = run_q & tickEnd & ~loadReq & (count_q == 32'h0000_0001);
  assign expiryFlag = count_q == 32'h0000_0000; // see RULE6

  always_ff @(posedge clk) begin
    if (rst || loadReq || !run_q || tickEnd) begin
      tick_q <= '0; // see RULE2
    end else begin
      tick_q <= tick_q + TW'(1); // see RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= PRESET_RST;
    end else if (loadReq) begin
      count_q <= preset_q; // see RULE7
    end else if (run_q && tickEnd && !expiryFlag) begin
      count_q <= count_q - 32'h0000_0001; // see RULE15
    end
  end

  // preset fetch and output apply
  iwd_ap_state_t apState_q;
  logic [2:0] fetchIdx_q;
  logic applyBase_q;
  logic [1:0] applyIdx_q;
  logic rdValid_q;
  logic [1:0] rdSlot_q;
  logic ovfPending_q;
  logic bootDone;
  logic rdBusy;
  logic rdDone;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] memRdata;
  iwd_ee_pins_t rdPins;

  assign bootDone = (apState_q == AP_WAIT) & rdDone & (fetchIdx_q == 3'h7);

  iwd_ee_reader #(
    .ABITS(EE_ADDR_W),
    .HALF(EE_HALF_CYCLES)
  ) u_reader (
    .clk(clk),
    .rst(rst),
    .start(apState_q == AP_FETCH),
    .addr(eeWordAddr(fetchIdx_q)), // see RULE11 see RULE12
    .doIn(doSync_q),
    .busy(rdBusy),
    .done(rdDone),
    .data(rdData),
    .pins(rdPins)
  );

  iwd_word_mem #(
    .WIDTH(DATA_W),
    .DEPTH(8)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .we((apState_q == AP_WAIT) & rdDone),
    .waddr(fetchIdx_q),
    .wdata(rdData),
    .raddr({applyBase_q, applyIdx_q}),
    .rdata(memRdata)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      apState_q <= AP_FETCH;
      fetchIdx_q <= 3'h0;
      applyBase_q <= 1'b0;
      applyIdx_q <= 2'h0;
      ovfPending_q <= 1'b0;
    end else begin
      if (expiry && apState_q != AP_IDLE) begin
        ovfPending_q <= 1'b1;
      end
      case (apState_q)
        AP_FETCH: begin
          apState_q <= AP_WAIT;
        end
        AP_WAIT: begin
          if (rdDone) begin
            fetchIdx_q <= fetchIdx_q + 3'h1;
            apState_q <= (fetchIdx_q == 3'h7) ? AP_APPLY : AP_FETCH;
            applyBase_q <= 1'b0; // see RULE11
            applyIdx_q <= 2'h0;
          end
        end
        AP_APPLY: begin
          applyIdx_q <= applyIdx_q + 2'h1;
          if (applyIdx_q == 2'h3) begin
            apState_q <= AP_IDLE;
          end
        end
        AP_IDLE: begin
          if (expiry || ovfPending_q) begin
            applyBase_q <= 1'b1; // see RULE16
            applyIdx_q <= 2'h0;
            ovfPending_q <= 1'b0;
            apState_q <= AP_APPLY;
          end
        end
        default: begin
          apState_q <= AP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid_q <= 1'b0;
      rdSlot_q <= 2'h0;
    end else begin
      rdValid_q <= apState_q == AP_APPLY;
      rdSlot_q <= applyIdx_q;
    end
  end

  // each word carries a port pair, lower port in the low byte
  always_ff @(posedge clk) begin
    if (rst) begin
      portOutputs <= '0;
    end else if (rdValid_q) begin
      portOutputs[rdSlot_q*DATA_W +: DATA_W] <= memRdata; // see RULE11 see RULE12 see RULE16
    end
  end

  // engine owns the pins until the boot fetch ends
  always_comb begin
    eePins = (apState_q == AP_FETCH || apState_q == AP_WAIT || rdBusy) ? rdPins : hostPins_q;
  end

  // interrupt status, write one to clear, set wins
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] statSet;

  always_comb begin
    statSet = '0;
    statSet[IRQ_EXPIRY_BIT] = expiry & irqEn_q; // see RULE4
    statSet[IRQ_BOOT_BIT] = bootDone;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wrStat ? pwdata[IRQ_W-1:0] : '0)) | statSet;
    end
  end

  assign irq = |(stat_q & mask_q);

  // read mux
  logic [DATA_W-1:0] rdMux;
  logic mapped;

  always_comb begin
    rdMux = '0;
    mapped = 1'b1;
    if (hit(paddr, IDX_PRESET_LO)) begin
      rdMux = preset_q[15:0]; // see RULE1
    end else if (hit(paddr, IDX_PRESET_HI)) begin
      rdMux = preset_q[31:16]; // see RULE1
    end else if (hit(paddr, IDX_CTL)) begin
      rdMux[CTL_RUN_BIT] = run_q; // see RULE5
      rdMux[CTL_IRQEN_BIT] = irqEn_q; // see RULE5
      rdMux[CTL_FLAG_BIT] = expiryFlag; // see RULE6
    end else if (hit(paddr, IDX_RELOAD)) begin
      rdMux = '0;
    end else if (hit(paddr, IDX_EE_PORT)) begin
      rdMux[EE_DO_BIT] = doSync_q; // see RULE9
    end else if (hit(paddr, IDX_CARD)) begin
      rdMux[3:0] = swSync_q; // see RULE13 see RULE14
    end else if (hit(paddr, IDX_IRQ_STAT)) begin
      rdMux[IRQ_W-1:0] = stat_q;
    end else if (hit(paddr, IDX_IRQ_MASK)) begin
      rdMux[IRQ_W-1:0] = mask_q;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rdMux};
      pslverr <= ~mapped;
    end
  end
endmodule

// ### verif/iwd_properties.sv
/* iwd_properties: port checks of iwd_top, bound in below.
   assumes an APB master that holds each request until pready. */
`timescale 1ns/1ns
module iwd_properties import iwd_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int EE_HALF_CYCLES = EE_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic eeDataOut,
  input wire iwd_ee_pins_t eePins,
  input wire logic [3:0] cardNumberSwitch,
  input wire logic [NUM_PORTS*PORT_W-1:0] portOutputs,
  input wire logic expiryFlag,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rdAcc;
  logic wrAcc;
  logic [1:0] ctlQ;
  logic [IRQ_W-1:0] maskQ;
  logic [15:0] loQ;
  logic [11:0] ageQ;
  assign rdAcc = psel && penable && !pwrite;
  assign wrAcc = psel && penable && pwrite;
  // mirrors of written registers, age since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ctlQ <= 2'h0;
      maskQ <= IRQ_MASK_RST;
      loQ <= PRESET_RST[15:0];
      ageQ <= 12'h0;
    end else begin
      if (wrAcc && paddr == byteAddr(IDX_CTL)) ctlQ <= pwdata[1:0];
      if (wrAcc && paddr == byteAddr(IDX_IRQ_MASK)) maskQ <= pwdata[IRQ_W-1:0];
      if (wrAcc && paddr == byteAddr(IDX_PRESET_LO)) loQ <= pwdata[15:0];
      if (ageQ != 12'hfff) ageQ <= ageQ + 12'h1;
    end
  end
  property p_preset_rd;
    rdAcc && paddr == byteAddr(IDX_PRESET_LO) |-> prdata[15:0] == loQ;
  endproperty
  a_preset_rd: assert property (p_preset_rd) else $error("preset readback");
  property p_ctl_rd;
    rdAcc && paddr == byteAddr(IDX_CTL) |-> prdata[1:0] == ctlQ;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
  property p_flag_rd;
    rdAcc && paddr == byteAddr(IDX_CTL) |-> prdata[2] == $past(expiryFlag);
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag readback");
  property p_card_rd;
    rdAcc && paddr == byteAddr(IDX_CARD) && cardNumberSwitch == $past(cardNumberSwitch, 4)
      |-> prdata[3:0] == cardNumberSwitch;
  endproperty
  a_card_rd: assert property (p_card_rd) else $error("card number");
  property p_flag_hold;
    $fell(expiryFlag) |->
      $past(wrAcc && (paddr == byteAddr(IDX_CTL) || paddr == byteAddr(IDX_RELOAD)));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_idle;
    !ctlQ[CTL_RUN_BIT] |-> !$rose(expiryFlag);
  endproperty
  a_idle: assert property (p_idle) else $error("expiry while off");
  property p_exp_irq;
    $rose(expiryFlag) && ctlQ == 2'h3 && maskQ[IRQ_EXPIRY_BIT] |-> ##[1:2] irq;
  endproperty
  a_exp_irq: assert property (p_exp_irq) else $error("no expiry irq");
  property p_irq_mask;
    maskQ == '0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  property p_ee_pins;
    wrAcc && paddr == byteAddr(IDX_EE_PORT) && ageQ == 12'hfff |=> eePins == $past(pwdata[3:1]);
  endproperty
  a_ee_pins: assert property (p_ee_pins) else $error("eeprom pins");
  c_expiry: cover property ($rose(expiryFlag));
  c_irq: cover property ($rose(irq));
  c_card: cover property (rdAcc && paddr == byteAddr(IDX_CARD));
endmodule

bind iwd_top iwd_properties #(.TICK_CYCLES(TICK_CYCLES), .EE_HALF_CYCLES(EE_HALF_CYCLES))
  i_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .eeDataOut(eeDataOut), .eePins(eePins), .cardNumberSwitch(cardNumberSwitch),
  .portOutputs(portOutputs), .expiryFlag(expiryFlag), .irq(irq));

// ### verif/iwd_ee_model.sv
/* iwd_ee_model: three-wire serial EEPROM, read command only.
   assumes pins registered on clk; data-out has no pull. */
`timescale 1ns/1ns
module iwd_ee_model import iwd_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire iwd_ee_pins_t pins,
  output logic dout
);
  logic sclkQ;
  logic [4:0] bitCnt;
  logic [8:0] cmdQ;
  logic [15:0] shQ;
  // word a holds {2'h1, a, 2'h2, a}
  function automatic logic [15:0] content(input logic [5:0] a);
    return {2'h1, a, 2'h2, a};
  endfunction
  always @(posedge clk) begin
    sclkQ <= pins.sclk;
    if (rst) begin
      dout <= 1'h0;
      bitCnt <= 5'h0;
    end else if (!pins.cs) begin
      bitCnt <= 5'h0;
      dout <= ~dout;
    end else if (pins.sclk && !sclkQ) begin
      bitCnt <= bitCnt + 5'h1;
      cmdQ <= {cmdQ[7:0], pins.di};
      if (bitCnt == 5'h9) begin
        {dout, shQ} <= {content(cmdQ[5:0]), 1'h0};
      end else begin
        {dout, shQ} <= {shQ, 1'h0};
      end
    end else if (bitCnt < 5'ha) begin
      dout <= ~dout;
    end
  end
endmodule

// ### verif/tb_io_card_watchdog_eeprom_id.sv
/* tb_io_card_watchdog_eeprom_id: self-checking bench of iwd_top.
   assumes iwd_ee_model on the serial port and the bound checker. */
`timescale 1ns/1ns
module tb_io_card_watchdog_eeprom_id import iwd_pkg::*; ;
  localparam int TICK = 5;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [PADDR_W-1:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic eeDataOut;
  iwd_ee_pins_t eePins;
  logic [3:0] cardNumberSwitch = 4'h0;
  logic [NUM_PORTS*PORT_W-1:0] portOutputs;
  logic expiryFlag;
  logic irq;
  int failCount = 0;
  int checked = 0;
  int n;
  int wdN;
  logic [31:0] seed = 32'hc8c0;
  logic [31:0] rd;
  logic err;
  logic [8:0] cmd;
  logic [15:0] eeExp;
  always #10 clk = ~clk;
  iwd_top #(.TICK_CYCLES(TICK), .EE_HALF_CYCLES(6)) i_dut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeDataOut(eeDataOut),
    .eePins(eePins), .cardNumberSwitch(cardNumberSwitch), .portOutputs(portOutputs),
    .expiryFlag(expiryFlag), .irq(irq));
  iwd_ee_model i_ee (.clk(clk), .rst(rst), .pins(eePins), .dout(eeDataOut));
  function automatic logic [15:0] eeWord(input logic [5:0] a);
    return {2'h1, a, 2'h2, a};
  endfunction
  function automatic logic [63:0] portSet(input logic [5:0] b);
    return {eeWord(b + 6'h3), eeWord(b + 6'h2), eeWord(b + 6'h1), eeWord(b)};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= byteAddr(idx);
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 20) begin
      failCount++;
      wrapUp();
    end
  endtask
  task automatic waitFlag();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (expiryFlag !== 1'h1 && n < 400);
    if (n >= 400) begin
      failCount++;
      wrapUp();
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 1000 && rd[IRQ_BOOT_BIT] !== 1'h1; i++) begin
      apb(1'h0, IDX_IRQ_STAT, 32'h0);
    end
    if (rd[IRQ_BOOT_BIT] !== 1'h1) begin
      failCount++;
      wrapUp();
    end
    // power-up words land a few clocks after the boot status bit
    repeat (8) @(posedge clk);
    chk("power-up outputs", portOutputs, portSet(EE_PWRUP_BASE));
    apb(1'h1, IDX_IRQ_MASK, 32'h2);
    @(negedge clk);
    chk("irq raised", irq, 1'h1);
    apb(1'h1, IDX_IRQ_STAT, 32'h2);
    @(negedge clk);
    chk("irq cleared", irq, 1'h0);
    apb(1'h0, 8'h50, 32'h0);
    chk("unmapped", {err, rd}, {1'h1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      cardNumberSwitch <= (i == 0) ? 4'h0 : (i == 1) ? 4'hf : seed[3:0];
      repeat (4) @(posedge clk);
      apb(1'h1, IDX_CARD, 32'h5);
      apb(1'h0, IDX_CARD, 32'h0);
      chk("card number", rd, {28'h0, cardNumberSwitch});
    end
    seed = lfsr(seed);
    apb(1'h1, IDX_PRESET_LO, {16'h0, seed[15:0]});
    apb(1'h1, IDX_PRESET_HI, {16'h0, seed[31:16]});
    apb(1'h0, IDX_PRESET_HI, 32'h0);
    chk("preset high", rd, {16'h0, seed[31:16]});
    wdN = 2 + int'(seed[2:0]);
    apb(1'h1, IDX_PRESET_LO, 32'(wdN));
    apb(1'h1, IDX_PRESET_HI, 32'h0);
    apb(1'h1, IDX_IRQ_MASK, 32'h1);
    apb(1'h1, IDX_CTL, 32'h3);
    waitFlag();
    chk("expiry time", 64'(n), 64'(wdN * TICK + 1));
    repeat (40) @(posedge clk);
    apb(1'h0, IDX_CTL, 32'h0);
    chk("control read", rd, 32'h7);
    chk("overflow outputs", portOutputs, portSet(EE_OVF_BASE));
    chk("expiry irq", irq, 1'h1);
    apb(1'h1, IDX_IRQ_STAT, 32'h1);
    apb(1'h1, IDX_RELOAD, 32'h0);
    apb(1'h1, IDX_RELOAD, 32'h1);
    waitFlag();
    chk("reload time", 64'(n), 64'(wdN * TICK - 2));
    chk("reload irq", irq, 1'h1);
    apb(1'h1, IDX_IRQ_STAT, 32'h1);
    apb(1'h1, IDX_CTL, 32'h1);
    apb(1'h1, IDX_CTL, 32'h0);
    repeat (1500) @(posedge clk);
    apb(1'h0, IDX_CTL, 32'h0);
    chk("disabled", rd, 32'h0);
    apb(1'h1, IDX_CTL, 32'h1);
    apb(1'h0, IDX_CTL, 32'h0);
    chk("counting", rd, 32'h1);
    waitFlag();
    apb(1'h0, IDX_IRQ_STAT, 32'h0);
    chk("no expiry event", rd[IRQ_EXPIRY_BIT], 1'h0);
    seed = lfsr(seed);
    cmd = {EE_READ_OP, seed[5:0]};
    eeExp = eeWord(seed[5:0]);
    for (int i = 8; i >= 0; i--) begin
      apb(1'h1, IDX_EE_PORT, {28'h0, 1'h1, 1'h0, cmd[i], 1'h0});
      apb(1'h1, IDX_EE_PORT, {28'h0, 1'h1, 1'h1, cmd[i], 1'h0});
    end
    for (int i = 15; i >= 0; i--) begin
      apb(1'h1, IDX_EE_PORT, 32'h8);
      apb(1'h1, IDX_EE_PORT, 32'hc);
      repeat (6) @(posedge clk);
      chk("serial pins", eePins, 3'h6);
      apb(1'h0, IDX_EE_PORT, 32'h0);
      chk("serial data", rd[EE_DO_BIT], eeExp[i]);
    end
    apb(1'h1, IDX_EE_PORT, 32'h0);
    wrapUp();
  end
endmodule
